//--- include/ascp_defs.svh
// timing counts, register offsets and frame layout for the serial control port master
`ifndef ASCP_DEFS_SVH
`define ASCP_DEFS_SVH
`define ASCP_FRAME_BITS      5'd24
`define ASCP_CMD_BITS        5'd8
`define ASCP_RSVD_BITS       2'b10
`define ASCP_CLK_MHZ         100
`define ASCP_SCLK_PERIOD_NS  160
`define ASCP_HALF_CYCLES     ((`ASCP_SCLK_PERIOD_NS * `ASCP_CLK_MHZ / 1000) / 2)
`define ASCP_GAP_NS          160
`define ASCP_GAP_CYCLES      ((`ASCP_GAP_NS * `ASCP_CLK_MHZ + 999) / 1000)
`define ASCP_OFS_CTRL        4'h0
`define ASCP_OFS_STATUS      4'h4
`define ASCP_OFS_RDATA       4'h8
`define ASCP_OFS_CFG         4'hC
`define ASCP_CTRL_GO         31
`define ASCP_CTRL_READ       20
`define ASCP_CTRL_ADDR_LSB   16
`define ASCP_CFG_THREE_WIRE  0
`define ASCP_CFG_EXT_CTRL    1
`define ASCP_DEV_MAIN_CONTROL       4'h0
`define ASCP_DEV_CH1_OFFSET         4'h2
`define ASCP_DEV_CH1_RANGE          4'h3
`define ASCP_DEV_CAL_ADJUST         4'h4
`define ASCP_DEV_INTERLEAVE_TIMING  4'h7
`define ASCP_DEV_CH2_OFFSET         4'hA
`define ASCP_DEV_CH2_RANGE          4'hB
`define ASCP_DEV_CLK_DELAY_COARSE   4'hC
`define ASCP_DEV_CLK_DELAY_FINE     4'hD
`define ASCP_DEV_SYNC_CLOCK_MODE    4'hE
`define ASCP_MC_CALIBRATE           15
`define ASCP_MC_OUTPUT_CLOCK_PHASE  14
`define ASCP_MC_OUTPUT_SWING        13
`define ASCP_MC_TEST_PATTERN        12
`define ASCP_MC_FIRST_CH_POWERDOWN  11
`define ASCP_MC_DUAL_EDGE           7
`define ASCP_MC_SECOND_INPUT        6
`define ASCP_MC_BOTH_INPUTS         5
`define ASCP_MC_TWOS_COMPLEMENT     4
`define ASCP_MC_TIMESTAMP           3
`define ASCP_MC_SINGLE_RATE         2
`define ASCP_MC_RESET               16'h0000
`endif

//--- include/ascp_pkg.sv
// types of the serial control port master
package ascp_pkg;
  typedef enum logic [2:0] {
    ASCP_IDLE,
    ASCP_LOW,
    ASCP_HIGH,
    ASCP_HOLD,
    ASCP_GAP
  } ascp_phase_t;

  typedef enum logic [1:0] {
    ASCP_AXI_IDLE,
    ASCP_AXI_WRESP,
    ASCP_AXI_RRESP
  } ascp_axi_t;

  typedef struct packed {
    ascp_phase_t phase;
    logic [7:0]  tick;
    logic [4:0]  bit_cnt;
    logic [23:0] shift;
    logic [15:0] rdata;
    logic        is_read;
    logic        busy;
    logic        done;
    logic [3:0]  addr;
    logic        three_wire;
    logic        ext_ctrl;
    logic [15:0] wdata;
    logic        go;
    logic        sclk;
    logic        sel_n;
    logic        sdi;
    logic        sdi_oe;
    logic [1:0]  sdo_sync;
    ascp_axi_t   axi;
    logic [31:0] axi_rdata;
    logic        axi_slverr;
  } ascp_state_t;
endpackage : ascp_pkg

//--- rtl/ascp_master.sv
// host master that drives the converter's 24-bit serial control port from AXI4-Lite registers
//
// The implementer's own choice: the AXI4-Lite register port.
`include "ascp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module ascp_master (
  input  wire logic                CORE_CLK,
  input  wire logic                RST,
  input  wire logic                CE,
  input  wire logic [3:0]          AWADDR,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  input  wire logic                WVALID,
  output logic                     WREADY,
  output logic [1:0]               BRESP,
  output logic                     BVALID,
  input  wire logic                BREADY,
  input  wire logic [3:0]          ARADDR,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  output logic [31:0]              RDATA,
  output logic [1:0]               RRESP,
  output logic                     RVALID,
  input  wire logic                RREADY,
  output logic                     SERIAL_SELECT_N,
  output logic                     SERIAL_CLK,
  output logic                     SERIAL_DATA_OUT,
  output logic                     SERIAL_DATA_OE,
  input  wire logic                SERIAL_DATA_IN,
  output logic                     EXTENDED_CONTROL_PIN_N
);
  import ascp_pkg::*;

  localparam logic [7:0] HALF = 8'(`ASCP_HALF_CYCLES);
  localparam logic [7:0] GAP  = 8'(`ASCP_GAP_CYCLES);

  ascp_state_t s;
  ascp_state_t next_s;
  logic        aw_ok;
  logic        ar_ok;

  // writes need both address and data present; reads wait for the write side
  // a frozen block offers no handshakes
  assign aw_ok   = CE && (s.axi == ASCP_AXI_IDLE) && AWVALID && WVALID;
  assign ar_ok   = CE && (s.axi == ASCP_AXI_IDLE) && ARVALID && !aw_ok;
  assign AWREADY = aw_ok;
  assign WREADY  = aw_ok;
  assign ARREADY = ar_ok;
  assign BVALID  = CE && (s.axi == ASCP_AXI_WRESP);
  assign BRESP   = {s.axi_slverr, 1'b0};
  assign RVALID  = CE && (s.axi == ASCP_AXI_RRESP);
  assign RDATA   = s.axi_rdata;
  assign RRESP   = 2'b00;

  assign SERIAL_SELECT_N        = s.sel_n;
  assign SERIAL_CLK             = s.sclk;
  assign SERIAL_DATA_OUT        = s.sdi;
  assign SERIAL_DATA_OE         = s.sdi_oe;
  assign EXTENDED_CONTROL_PIN_N = s.ext_ctrl;

  always_comb begin
    next_s = s;
    next_s.sdo_sync = {s.sdo_sync[0], SERIAL_DATA_IN};
    // bus slave
    unique case (s.axi)
      ASCP_AXI_IDLE: begin
        if (aw_ok) begin
          next_s.axi        = ASCP_AXI_WRESP;
          next_s.axi_slverr = 1'b0;
          unique case (AWADDR)
            `ASCP_OFS_CTRL: begin
              if (s.busy || s.go) begin
                next_s.axi_slverr = 1'b1;
              end else if (WSTRB == 4'hF) begin
                next_s.go      = WDATA[`ASCP_CTRL_GO];
                next_s.is_read = WDATA[`ASCP_CTRL_READ];
                next_s.addr    = WDATA[`ASCP_CTRL_ADDR_LSB +: 4];
                next_s.wdata   = WDATA[15:0];
              end
            end
            `ASCP_OFS_CFG: begin
              if (WSTRB[0]) begin
                next_s.three_wire = WDATA[`ASCP_CFG_THREE_WIRE];
                next_s.ext_ctrl   = WDATA[`ASCP_CFG_EXT_CTRL];
              end
            end
            `ASCP_OFS_STATUS, `ASCP_OFS_RDATA: begin
            end
            default: next_s.axi_slverr = 1'b1;
          endcase
        end else if (ar_ok) begin
          next_s.axi = ASCP_AXI_RRESP;
          unique case (ARADDR)
            `ASCP_OFS_CTRL:   next_s.axi_rdata = {s.go, 10'h000, s.is_read, s.addr, s.wdata};
            `ASCP_OFS_STATUS: next_s.axi_rdata = {30'h00000000, s.done, s.busy | s.go};
            `ASCP_OFS_RDATA:  next_s.axi_rdata = {16'h0000, s.rdata};
            `ASCP_OFS_CFG:    next_s.axi_rdata = {30'h00000000, s.ext_ctrl, s.three_wire};
            default:          next_s.axi_rdata = 32'h00000000;
          endcase
          if (ARADDR == `ASCP_OFS_RDATA) begin
            next_s.done = 1'b0;
          end
        end
      end
      ASCP_AXI_WRESP: begin
        if (BREADY) begin
          next_s.axi = ASCP_AXI_IDLE;
        end
      end
      ASCP_AXI_RRESP: begin
        if (RREADY) begin
          next_s.axi = ASCP_AXI_IDLE;
        end
      end
      default: next_s.axi = ASCP_AXI_IDLE;
    endcase
    // serial frame engine
    unique case (s.phase)
      ASCP_IDLE: begin
        next_s.sclk    = 1'b0;
        next_s.sel_n   = 1'b1;
        next_s.sdi_oe  = 1'b0;
        next_s.bit_cnt = 5'd0;
        if (s.go) begin
          next_s.go      = 1'b0;
          next_s.busy    = 1'b1;
          next_s.done    = 1'b0;
          next_s.sel_n   = 1'b0;
          next_s.shift   = {s.is_read, `ASCP_RSVD_BITS, s.addr, 1'b0, s.wdata};
          next_s.sdi     = s.is_read;
          next_s.sdi_oe  = 1'b1;
          next_s.tick    = 8'd0;
          next_s.phase   = ASCP_LOW;
        end
      end
      ASCP_LOW: begin
        if (s.tick == HALF - 8'd1) begin
          next_s.tick    = 8'd0;
          next_s.sclk    = 1'b1;
          next_s.bit_cnt = s.bit_cnt + 5'd1;
          next_s.phase   = ASCP_HIGH;
          // read data bit sampled just before the rise the device holds it for
          if (s.is_read && s.bit_cnt >= `ASCP_CMD_BITS) begin
            next_s.rdata = {s.rdata[14:0], s.sdo_sync[1]};
          end
        end else begin
          next_s.tick = s.tick + 8'd1;
        end
      end
      ASCP_HIGH: begin
        // turnaround: release shared line one cycle ahead of the eighth fall
        if (s.is_read && s.bit_cnt == `ASCP_CMD_BITS && s.three_wire && s.tick == HALF - 8'd2) begin
          next_s.sdi_oe = 1'b0;
        end
        if (s.tick == HALF - 8'd1) begin
          next_s.tick  = 8'd0;
          next_s.sclk  = 1'b0;
          next_s.shift = {s.shift[22:0], 1'b0};
          next_s.sdi   = s.shift[22];
          if (s.bit_cnt == `ASCP_FRAME_BITS) begin
            next_s.phase = ASCP_HOLD;
          end else begin
            next_s.phase = ASCP_LOW;
          end
        end else begin
          next_s.tick = s.tick + 8'd1;
        end
      end
      ASCP_HOLD: begin
        if (s.tick == HALF - 8'd1) begin
          next_s.tick   = 8'd0;
          next_s.sel_n  = 1'b1;
          next_s.sdi_oe = 1'b0;
          next_s.phase  = ASCP_GAP;
        end else begin
          next_s.tick = s.tick + 8'd1;
        end
      end
      ASCP_GAP: begin
        if (s.tick >= GAP - 8'd1) begin
          next_s.tick  = 8'd0;
          next_s.busy  = 1'b0;
          next_s.done  = 1'b1;
          next_s.phase = ASCP_IDLE;
        end else begin
          next_s.tick = s.tick + 8'd1;
        end
      end
      default: next_s.phase = ASCP_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s            <= '0;
      s.phase      <= ASCP_IDLE;
      s.axi        <= ASCP_AXI_IDLE;
      s.sel_n      <= 1'b1;
      s.ext_ctrl   <= 1'b0;
      s.sdo_sync   <= 2'b00;
    end else if (CE) begin
      s <= next_s;
    end
  end

  // frames always close after exactly 24 rises
  property frame_len_p;
    @(posedge CORE_CLK) disable iff (RST)
      (CE && $rose(s.sel_n)) |-> (s.bit_cnt == `ASCP_FRAME_BITS);
  endproperty
  frame_len_a: assert property (frame_len_p) else $error("frame not 24 bits");

  select_first_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(s.sel_n) |-> (s.sdi_oe && !s.sclk && s.bit_cnt == 5'd0)) else $error("bad frame start");

  clock_park_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    s.sel_n |-> !s.sclk) else $error("clock not parked low");

  line_release_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.three_wire && s.is_read && !s.sel_n && s.bit_cnt == 5'd8 && $fell(s.sclk)) |->
    (!s.sdi_oe && !$past(s.sdi_oe)))
    else $error("shared line still driven");

  gap_high_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && $rose(s.sel_n)) |=> s.sel_n[*2]) else $error("select gap too short");

  cmd_bits_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!s.sel_n && s.sclk && s.bit_cnt == 5'd2) |-> s.sdi) else $error("reserved bit wrong");

  count_clear_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.phase == ASCP_IDLE && CE) |=> (s.bit_cnt == 5'd0)) else $error("counter not cleared");

  dir_bit_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!s.sel_n && s.sclk && s.bit_cnt == 5'd1) |-> (s.sdi == s.is_read)) else $error("direction bit wrong");

  bit3_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!s.sel_n && s.sclk && s.bit_cnt == 5'd3) |->
    !s.sdi)
    else $error("reserved bit three wrong");

  addr_bits_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!s.sel_n && s.sclk && s.bit_cnt >= 5'd4 && s.bit_cnt <= 5'd7) |->
    (s.sdi == s.addr[2'(5'd7 - s.bit_cnt)]))
    else $error("address bit wrong");

  pad_bit_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!s.sel_n && s.sclk && s.bit_cnt == 5'd8) |->
    !s.sdi)
    else $error("pad bit not zero");

  data_bits_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!s.sel_n && s.sclk && !s.is_read && s.bit_cnt >= 5'd9) |->
    (s.sdi == s.wdata[4'(5'd24 - s.bit_cnt)]))
    else $error("write data bit wrong");

  change_at_fall_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!s.sel_n && !$fell(s.sel_n) && $changed(s.sdi)) |->
    $fell(s.sclk))
    else $error("data changed off a falling edge");

  high_time_a: assert property (@(posedge CORE_CLK) disable iff (RST || !CE)
    $rose(s.sclk) |->
    (s.sclk[*8] ##1 !s.sclk))
    else $error("clock high time wrong");

  low_time_a: assert property (@(posedge CORE_CLK) disable iff (RST || !CE)
    (!s.sel_n && $fell(s.sclk)) |->
    ((!s.sclk)[*8] ##1 (s.sclk || s.sel_n)))
    else $error("clock low time wrong");

  first_rise_a: assert property (@(posedge CORE_CLK) disable iff (RST || !CE)
    $fell(s.sel_n) |->
    ((!s.sclk)[*8] ##1 s.sclk))
    else $error("first rise not one half period after select");

  four_wire_oe_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!s.three_wire && !s.sel_n) |->
    s.sdi_oe)
    else $error("four-wire line not driven");

  idle_release_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    s.sel_n |->
    !s.sdi_oe)
    else $error("line driven outside a frame");

  count_limit_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    !s.sel_n |->
    (s.bit_cnt <= `ASCP_FRAME_BITS))
    else $error("more than 24 clocks in a frame");

  read_release_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.three_wire && s.is_read && !s.sel_n && s.bit_cnt > `ASCP_CMD_BITS) |->
    !s.sdi_oe)
    else $error("shared line driven during read data");

  start_clears_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    $fell(s.sel_n) |->
    (!s.go && s.busy && !s.done))
    else $error("frame start flags wrong");

  gap_length_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(s.sel_n) |->
    (s.sel_n[*8] ##1 s.sel_n[*8]))
    else $error("select gap shorter than 16 cycles");

  read_capture_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s.is_read && !s.sel_n && $rose(s.sclk) && s.bit_cnt >= 5'd9) |->
    (s.rdata[0] == $past(s.sdo_sync[1])))
    else $error("read bit not captured");

  rdata_hold_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    $changed(s.rdata) |->
    (s.is_read && $rose(s.sclk)))
    else $error("read data changed outside a read rise");

  done_set_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(s.done) |->
    (s.phase == ASCP_IDLE && s.sel_n && !s.busy))
    else $error("done raised inside a frame");
endmodule : ascp_master
`default_nettype wire

//--- bench/ascp_dev.sv
// behavioural model of the converter's serial control port
`timescale 1ns/1ps
`default_nettype none
module ascp_dev (
  input  wire logic sel_n,
  input  wire logic sclk,
  input  wire logic sdi,
  input  wire logic mst_oe,
  input  wire logic three_wire,
  input  wire logic ext_n,
  output logic      sdo,
  output logic      sdo_oe,
  output logic      err
);
  logic [15:0] regs [16];
  logic [23:0] sh;
  logic [15:0] rd;
  int          cnt;
  int          idx;
  function automatic logic mapped(input logic [3:0] a);
    return ((16'h7C9D >> a) & 1) != 0;
  endfunction : mapped
  initial begin
    err = 1'h0;
    cnt = 0;
    sdo = 1'h0;
    sdo_oe = 1'h0;
    idx = 15;
    foreach (regs[i]) regs[i] = 16'h0000;
  end
  always @(ext_n) if (ext_n) foreach (regs[i]) regs[i] = 16'h0000;
  always @(negedge sel_n) if (sclk) err = 1'h1;
  always @(posedge sel_n) begin
    if (cnt != 24 && cnt != 0) err = 1'h1;
    cnt = 0;
    sdo_oe = 1'h0;
    sdo = ~sdo;
  end
  always @(posedge sclk) begin
    if (!sel_n) begin
      if (cnt == 8 && sh[7] && three_wire && mst_oe) err = 1'h1;
      if (cnt == 24) err = 1'h1;
      else begin
        sh = {sh[22:0], sdi};
        cnt++;
        if (cnt == 24 && sh[22:21] !== 2'h2) err = 1'h1;
        if (cnt == 24 && !sh[23] && !ext_n && mapped(sh[20:17])) regs[sh[20:17]] = sh[15:0];
      end
    end
  end
  always @(negedge sclk) begin
    if (!sel_n && cnt == 8 && sh[7] && three_wire && mst_oe) err = 1'h1;
    if (!sel_n && cnt == 8 && sh[7]) begin
      rd = mapped(sh[4:1]) ? regs[sh[4:1]] : 16'h0000;
      idx = 15;
      sdo_oe = 1'h1;
    end else if (sdo_oe && idx > 0) idx--;
    if (sdo_oe) sdo = rd[idx];
  end
endmodule : ascp_dev
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the serial control port master
`include "ascp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk = 1'h0;
  logic        rst = 1'h1;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, three = 1'h0;
  logic        ce = 1'h1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, sel_n, sclk, m_out, m_oe, ext_n, sdo, sdo_oe, err;
  wire         line = m_oe ? m_out : (sdo_oe ? sdo : 1'h1);
  int          checks = 0, fail_count = 0;
  always #5 core_clk = ~core_clk;
  ascp_master i_ascp_master (
    .CORE_CLK(core_clk), .RST(rst), .CE(ce), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .SERIAL_SELECT_N(sel_n), .SERIAL_CLK(sclk), .SERIAL_DATA_OUT(m_out),
    .SERIAL_DATA_OE(m_oe), .SERIAL_DATA_IN(three ? line : sdo), .EXTENDED_CONTROL_PIN_N(ext_n));
  ascp_dev i_ascp_dev (
    .sel_n(sel_n), .sclk(sclk), .sdi(three ? line : (m_oe ? m_out : 1'h1)), .mst_oe(m_oe),
    .three_wire(three), .ext_n(ext_n), .sdo(sdo), .sdo_oe(sdo_oe), .err(err));
  task automatic end_of_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tmo(input logic hit);
    if (hit) begin
      fail_count++;
      end_of_test();
    end
  endtask : tmo
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    n = 0;
    do @(negedge core_clk); while (!(awready && wready) && ++n < 50);
    tmo(n == 50);
    @(posedge core_clk);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    n = 0;
    do @(negedge core_clk); while (!bvalid && ++n < 50);
    tmo(n == 50);
    cmp(bresp, resp);
    @(posedge core_clk);
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    n = 0;
    do @(negedge core_clk); while (!arready && ++n < 50);
    tmo(n == 50);
    @(posedge core_clk);
    arvalid <= 1'h0;
    n = 0;
    do @(negedge core_clk); while (!rvalid && ++n < 50);
    tmo(n == 50);
    d = rdata;
    cmp(rresp, 2'h0);
    @(posedge core_clk);
    rready <= 1'h0;
  endtask : rd
  task automatic finish(output logic [15:0] q);
    logic [31:0] s;
    int n;
    n = 0;
    do rd(`ASCP_OFS_STATUS, s); while (s[1:0] !== 2'h2 && ++n < 200);
    tmo(n == 200);
    rd(`ASCP_OFS_RDATA, s);
    q = s[15:0];
  endtask : finish
  task automatic frame(input logic r, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
    wr(`ASCP_OFS_CTRL, {1'h1, 10'h0, r, a, d}, 2'h0);
    finish(q);
  endtask : frame
  task automatic t_reset;
    logic [31:0] s;
    @(negedge core_clk);
    cmp({sel_n, sclk, m_oe, ext_n}, 4'h8);
    rd(`ASCP_OFS_STATUS, s);
    cmp(s, 32'h0);
  endtask : t_reset
  task automatic t_regs;
    logic [15:0] d, q;
    for (int a = 0; a < 16; a++) begin
      d = {a[3:0], ~a[3:0], a[3:0] ^ 4'h5, 4'hC};
      frame(1'h0, a[3:0], d, q);
      cmp(i_ascp_dev.regs[a], ((16'h7C9D >> a) & 1) != 0 ? d : 16'h0);
      frame(1'h1, a[3:0], 16'h0, q);
      cmp(q, ((16'h7C9D >> a) & 1) != 0 ? d : 16'h0);
    end
  endtask : t_regs
  task automatic t_busy;
    logic [15:0] q;
    logic [31:0] s;
    wr(`ASCP_OFS_CTRL, {1'h1, 10'h0, 1'h0, 4'h2, 16'hA5A5}, 2'h0);
    wr(`ASCP_OFS_CTRL, {1'h1, 10'h0, 1'h0, 4'h2, 16'h5A5A}, 2'h2);
    finish(q);
    rd(`ASCP_OFS_CTRL, s);
    cmp(s, {1'h0, 10'h0, 1'h0, 4'h2, 16'hA5A5});
    frame(1'h1, 4'h2, 16'h0, q);
    cmp(q, 16'hA5A5);
  endtask : t_busy
  task automatic t_three;
    logic [15:0] q;
    logic [31:0] s;
    wr(`ASCP_OFS_CFG, 32'h1, 2'h0);
    rd(`ASCP_OFS_CFG, s);
    cmp(s, 32'h1);
    three <= 1'h1;
    frame(1'h0, 4'h7, 16'hC3E1, q);
    frame(1'h1, 4'h7, 16'h0, q);
    cmp(q, 16'hC3E1);
    wr(`ASCP_OFS_CFG, 32'h0, 2'h0);
    three <= 1'h0;
  endtask : t_three
  task automatic t_freeze;
    logic [15:0] q;
    logic [3:0]  p;
    wr(`ASCP_OFS_CTRL, {1'h1, 10'h0, 1'h0, 4'hD, 16'h3C5A}, 2'h0);
    repeat (100) @(posedge core_clk);
    ce <= 1'h0;
    @(negedge core_clk);
    p = {sel_n, sclk, m_out, m_oe};
    cmp(p[3], 1'h0);
    repeat (40) @(negedge core_clk);
    cmp({sel_n, sclk, m_out, m_oe}, p);
    @(posedge core_clk);
    ce <= 1'h1;
    finish(q);
    frame(1'h1, 4'hD, 16'h0, q);
    cmp(q, 16'h3C5A);
  endtask : t_freeze
  task automatic t_ext;
    logic [15:0] q;
    frame(1'h0, 4'h0, 16'hF8FC, q);
    frame(1'h1, 4'h0, 16'h0, q);
    cmp(q, 16'hF8FC);
    wr(`ASCP_OFS_CFG, 32'h2, 2'h0);
    @(negedge core_clk);
    cmp(ext_n, 1'h1);
    wr(`ASCP_OFS_CFG, 32'h0, 2'h0);
    frame(1'h1, 4'h0, 16'h0, q);
    cmp(q, 16'h0);
  endtask : t_ext
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    t_reset();
    t_regs();
    t_busy();
    t_three();
    t_ext();
    t_freeze();
    cmp(err, 1'h0);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
